/* File: bench/dbc_debug_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
    miscompares++; $display("unexpected %0t mismatch", $time); end end
module dbc_debug_control_tb_top;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic opcode_decode = 0, read_protect = 0, serial_break = 0;
    logic pready, pslverr, fetch_halt, dev_reset_req, reset_seq_done;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [7:0] opcode = 8'hFF;
    int compares = 0, miscompares = 0;
    dbc_debug_control dbc_debug_control_i (.sys_clk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
        .opcode_decode, .opcode, .fetch_halt, .read_protect, .serial_break,
        .reset_seq_done, .dev_reset_req);
    dbc_seq_model dbc_seq_model_i (.sys_clk, .dev_reset_req, .reset_seq_done);
    task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rd(logic [7:0] x);
        apb(1'b0, 12'h000, 8'h00);
        `CHK(q, {24'h0, x})
    endtask : rd
    task automatic op(logic [7:0] c);
        @(posedge sys_clk);
        {opcode_decode, opcode} <= {1'b1, c};
        @(posedge sys_clk);
        opcode_decode <= 1'b0;
    endtask : op
    task automatic final_report;
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial forever #5 sys_clk = ~sys_clk;
    // Whole run needs about 60 cycles
    initial begin
        #20000;
        miscompares++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h00);
        apb(1'b1, 12'h000, 8'hFE);
        rd(8'hE0);
        `CHK(fetch_halt, 1'b1)
        apb(1'b1, 12'h000, 8'h40);
        rd(8'h40);
        `CHK(fetch_halt, 1'b0)
        op(8'h00);
        serial_break <= 1'b1;
        rd(8'hC0);
        read_protect <= 1'b1;
        apb(1'b1, 12'h000, 8'h41);
        repeat (2) @(posedge sys_clk);
        `CHK(dev_reset_req, 1'b1)
        repeat (10) @(posedge sys_clk);
        `CHK(dev_reset_req, 1'b0)
        rd(8'hC0);
        {read_protect, serial_break} <= 2'b00;
        apb(1'b1, 12'h000, 8'h00);
        op(8'h00);
        rd(8'h00);
        `CHK(fetch_halt, 1'b0)
        apb(1'b0, 12'h004, 8'h00);
        `CHK(e, 1'b1)
        `CHK(q, 32'h0000_0000)
        final_report;
    end
endmodule : dbc_debug_control_tb_top
`default_nettype wire

/* File: bench/dbc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dbc_monitor (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Core, protection and sequencer
    input wire logic [7:0]  opcode,
    input wire logic        opcode_decode,
    input wire logic        fetch_halt,
    input wire logic        read_protect,
    input wire logic        reset_seq_done,
    input wire logic        dev_reset_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic wr, bk, en_r;
    assign wr = psel && penable && pwrite && paddr == 12'h000;
    assign bk = opcode_decode && opcode == 8'h00;
    // Shadow of enable bit, ports show it nowhere else
    always_ff @(posedge sys_clk) begin
        if (rst) en_r <= 1'b0;
        else if (wr) en_r <= pwdata[6];
    end
    AST_HALT: assert property (wr && pwdata[7] |=> fetch_halt)
        else $error("halt not set");
    AST_RESUME: assert property (wr && !pwdata[7] && !read_protect && !bk
        |=> !fetch_halt) else $error("no resume");
    AST_LOCK: assert property (fetch_halt && read_protect |=> fetch_halt)
        else $error("protect lost");
    AST_BREAK: assert property (bk && en_r && !wr |=> fetch_halt)
        else $error("break missed");
    AST_RSVD: assert property (psel && !pwrite && paddr == 12'h000
        |-> prdata[4:1] == 4'h0 && prdata[31:8] == 24'h00_0000)
        else $error("reserved set");
    AST_RST: assert property (wr && pwdata[0] && !dev_reset_req
        |-> ##2 dev_reset_req) else $error("no reset");
    AST_DONE: assert property (reset_seq_done && $past(dev_reset_req)
        && dev_reset_req |=> !dev_reset_req) else $error("stuck");
    AST_KEEP: assert property (!wr && !bk |=> $stable(fetch_halt))
        else $error("halt moved");
    cover property (bk && en_r);
    cover property ($rose(dev_reset_req));
    cover property (wr && read_protect && fetch_halt);
endmodule : dbc_monitor
bind dbc_debug_control dbc_monitor dbc_monitor_i (.sys_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .opcode, .opcode_decode,
    .fetch_halt, .read_protect, .reset_seq_done, .dev_reset_req);
`default_nettype wire

/* File: bench/dbc_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dbc_seq_model (
    // Sequencer handshake
    input  wire logic sys_clk,
    input  wire logic dev_reset_req,
    output var  logic reset_seq_done
);
    always_ff @(posedge sys_clk) reset_seq_done <= dev_reset_req;
endmodule : dbc_seq_model
`default_nettype wire

/* File: include/dbc_pkg.sv */
package dbc_pkg;
    typedef enum logic [1:0] {
        DBC_RST_IDLE = 2'b00,
        DBC_RST_REQ  = 2'b01,
        DBC_RST_WAIT = 2'b10
    } dbc_rst_state_type;
endpackage : dbc_pkg

/* File: include/dbc_regs.svh */
// Operation
// RL1: Bit 7 set means debug mode; clear means normal mode.
// RL2: In debug mode the core fetches no further instructions.
// RL3: Writing 0 to bit 7, when allowed, resumes core execution.
// RL4: Break opcode decoded with breakpoints enabled sets bit 7 in hardware.
// RL5: With read protect active, writing 0 to bit 7 is ignored.
// RL6: Bit 6 enables breakpoints; when 0, break opcode 00H acts as no-op.
// RL7: Reserved bits 4 to 1 always read as zero.
// RL8: Writing 1 to bit 0 starts a device reset; writing 0 does nothing.
// RL9: Requested reset follows power-on sequence but spares the debugger.
// RL10: Hardware clears bit 0 when the reset sequence completes.
// RL11: A serial break leaves every bit of this register unchanged.
// RL12: Bit 5 is plain read/write storage with no side effect.
`ifndef DBC_REGS_SVH
`define DBC_REGS_SVH
`define DBC_CTRL_ADDR    12'h000
`define DBC_HALT_BIT     7
`define DBC_BPEN_BIT     6
`define DBC_ACK_BIT      5
`define DBC_RST_BIT      0
`define DBC_CTRL_RESET   8'h00
`define DBC_CTRL_WMASK   8'hE1
`define DBC_BREAK_OPCODE 8'h00
`define DBC_RSVD_LSB     1
`define DBC_RSVD_MSB     4
`define DBC_CTRL_LANE    0
`endif

/* File: verilog/dbc_debug_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dbc_regs.svh"
module dbc_debug_control #(
    // Bus and register sizes
    parameter int ADDR_W = 12,
    parameter int DATA_W = 32,
    parameter int CTRL_W = 8
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    input  wire logic [DATA_W/8-1:0] pstrb,
    output var  logic [DATA_W-1:0]   prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // Core side
    input  wire logic                opcode_decode,
    input  wire logic [7:0]          opcode,
    output var  logic                fetch_halt,
    // Protection and link
    input  wire logic                read_protect,
    input  wire logic                serial_break,
    // Reset sequencer
    input  wire logic                reset_seq_done,
    output var  logic                dev_reset_req
);
    import dbc_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Constants

    // Reset image of the whole register; each stored bit takes its own slice, reserved bits 4 to 1 are tied to zero
    localparam logic [CTRL_W-1:0] CTRL_RESET_C = `DBC_CTRL_RESET;
    // Bits that a write may change; reserved bits ignore the bus
    localparam logic [CTRL_W-1:0] WMASK_C      = `DBC_CTRL_WMASK;
    localparam logic [7:0]        BREAK_OP_C   = `DBC_BREAK_OPCODE;
    // Single word map; the offset is a local choice
    localparam logic [ADDR_W-1:0] CTRL_ADDR_C  = `DBC_CTRL_ADDR;
    localparam int                RSVD_LO      = `DBC_RSVD_LSB;
    localparam int                RSVD_HI      = `DBC_RSVD_MSB;
    localparam int                LANE_C       = `DBC_CTRL_LANE;

    ////////////////////////////////////////////////////////////////
    // Register state and decode nets

    logic                    halt_mode_flag_r;
    logic                    breakpoint_enable_r;
    logic                    halt_acknowledge_r;
    logic                    reset_bit_r;
    logic                    setup_rd;
    logic                    setup_err;
    logic                    wr_ctrl;
    logic                    break_hit;
    logic                    rst_done;
    logic       [CTRL_W-1:0] wr_bits;
    // Read image is a net: each field drives its own bit
    wire  logic [CTRL_W-1:0] ctrl_rd;
    logic       [DATA_W-1:0] prdata_r;
    logic                    pslverr_r;

    ////////////////////////////////////////////////////////////////
    // Decode helpers

    // One register only; every other word is unmapped
    function automatic logic ctrl_hit(input logic [ADDR_W-1:0] addr);
        return (addr == CTRL_ADDR_C);
    endfunction : ctrl_hit

    // Only the low lane carries the register; upper lanes are dropped
    function automatic logic [CTRL_W-1:0] lane_bits(
        input logic [DATA_W-1:0] data
    );
        return data[CTRL_W-1:0] & WMASK_C;
    endfunction : lane_bits

    // Break opcode compare; no other opcode halts the core
    function automatic logic is_break(input logic [7:0] code);
        return (code == BREAK_OP_C);
    endfunction : is_break

    ////////////////////////////////////////////////////////////////
    // APB decode

    // Zero wait states: every access phase is answered at once
    assign pready = 1'b1;

    // Read data and error are captured in the setup cycle
    assign setup_rd  = psel && !penable && !pwrite && ctrl_hit(paddr);
    assign setup_err = psel && !penable && !ctrl_hit(paddr);

    // A write lands at the edge that closes the access phase
    // Limitation: a write with the low lane strobe clear is dropped
    assign wr_ctrl = psel && penable && pwrite && ctrl_hit(paddr)
                     && pstrb[LANE_C];
    assign wr_bits = lane_bits(pwdata);

    ////////////////////////////////////////////////////////////////
    // Read-back image

    // RL7: reserved read zero
    for (genvar gi = RSVD_LO; gi <= RSVD_HI; gi++) begin : g_rsvd
        assign ctrl_rd[gi] = 1'b0;
    end

    assign ctrl_rd[`DBC_HALT_BIT] = halt_mode_flag_r;
    assign ctrl_rd[`DBC_BPEN_BIT] = breakpoint_enable_r;
    assign ctrl_rd[`DBC_ACK_BIT]  = halt_acknowledge_r;
    assign ctrl_rd[`DBC_RST_BIT]  = reset_bit_r;

    // Idle zero keeps stale data off the bus between reads
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_r <= '0;
        end else if (setup_rd) begin
            prdata_r <= DATA_W'(ctrl_rd);
        end else begin
            prdata_r <= '0;
        end
    end

    assign prdata = prdata_r;

    // Unmapped words answer with an error and no side effect
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= setup_err;
        end
    end

    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////
    // Debug mode

    // RL6: break opcode gated
    // Disabled breakpoints let the opcode pass as a no-op
    assign break_hit = opcode_decode && breakpoint_enable_r
                       && is_break(opcode);

    // RL1: debug mode flag
    // RL11: no serial break term
    // serial_break is left unread: the link restarts, this state persists
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halt_mode_flag_r <= CTRL_RESET_C[`DBC_HALT_BIT];
        end else if (break_hit) begin
            // RL4: break sets flag
            // Break wins over a same-cycle write so no halt is lost
            halt_mode_flag_r <= 1'b1;
        end else if (wr_ctrl) begin
            // RL3: clear resumes
            // RL5: protect blocks clear
            if (wr_bits[`DBC_HALT_BIT] || !read_protect) begin
                halt_mode_flag_r <= wr_bits[`DBC_HALT_BIT];
            end
        end
    end

    // RL2: halt fetch
    // Straight from the flop, so the core sees no decode glitch
    assign fetch_halt = halt_mode_flag_r;

    ////////////////////////////////////////////////////////////////
    // Breakpoint enable and acknowledge

    // RL6: enable storage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            breakpoint_enable_r <= CTRL_RESET_C[`DBC_BPEN_BIT];
        end else if (wr_ctrl) begin
            breakpoint_enable_r <= wr_bits[`DBC_BPEN_BIT];
        end
    end

    // RL12: plain storage
    // No side effect is wired; the bit only reads back what was written
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halt_acknowledge_r <= CTRL_RESET_C[`DBC_ACK_BIT];
        end else if (wr_ctrl) begin
            halt_acknowledge_r <= wr_bits[`DBC_ACK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Device reset request

    // RL8: write one starts
    // RL10: self clear at end
    // Writing 0 to the bit leaves it alone
    // Set wins over a completion in the same cycle, so a fresh request
    // is never swallowed by the end of the previous one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reset_bit_r <= CTRL_RESET_C[`DBC_RST_BIT];
        end else if (wr_ctrl && wr_bits[`DBC_RST_BIT]) begin
            reset_bit_r <= 1'b1;
        end else if (rst_done) begin
            reset_bit_r <= 1'b0;
        end
    end

    // RL9: spare debugger
    // Only the device side sees the request; rst alone clears this block
    dbc_reset_seq dbc_reset_seq_i (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .start         (reset_bit_r),
        .seq_done      (reset_seq_done),
        .dev_reset_req (dev_reset_req),
        .done          (rst_done)
    );
endmodule : dbc_debug_control
`default_nettype wire

/* File: verilog/dbc_reset_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module dbc_reset_seq (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Request and sequencer
    input  wire logic start,
    input  wire logic seq_done,
    output var  logic dev_reset_req,
    output var  logic done
);
    import dbc_pkg::*;

    dbc_rst_state_type state_r;

    ////////////////////////////////////////////////////////////////
    // RL9: spare debugger
    // Only the sequencer below sees the request; debugger keeps its state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= DBC_RST_IDLE;
        end else begin
            case (state_r)
                DBC_RST_IDLE: begin
                    if (start) begin
                        state_r <= DBC_RST_REQ;
                    end
                end
                DBC_RST_REQ: begin
                    state_r <= DBC_RST_WAIT;
                end
                DBC_RST_WAIT: begin
                    if (seq_done) begin
                        state_r <= DBC_RST_IDLE;
                    end
                end
                default: begin
                    state_r <= DBC_RST_IDLE;
                end
            endcase
        end
    end

    assign dev_reset_req = (state_r != DBC_RST_IDLE);
    assign done          = (state_r == DBC_RST_WAIT) && seq_done;
endmodule : dbc_reset_seq
`default_nettype wire
